//--- hdl/personality_prom_bit_access.sv
// Module: AXI4-Lite register access to a 64-cell personality prom
`timescale 1ns/1ps
module personality_prom_bit_access (
  input  wire logic        mclk,          // Bus clock, 250 MHz
  input  wire logic        arst_n,        // Asynchronous reset, active low
  input  wire logic [3:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output logic             s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes
  input  wire logic        s_wvalid,      // Write data valid
  output logic             s_wready,      // Write data ready
  output logic [1:0]       s_bresp,       // Write response
  output logic             s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [3:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output logic             s_arready,     // Read address ready
  output logic [31:0]      s_rdata,       // Read data
  output logic [1:0]       s_rresp,       // Read response
  output logic             s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  output logic [5:0]       cellRow,       // One-hot-free row index to array
  output logic [5:0]       cellSelect,    // Selected cell index to array
  input  wire logic        senseIn,       // Sense amplifier output, async
  output logic             programSupplyEnable // Enable toward high-voltage switch
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [7:0]  cellSel_q;                 // Cell select register
  logic        pgm_q;                     // Program supply enable bit
  logic        senseMeta_q;               // Sense synchroniser stage one
  logic        sensed_q;                  // Sensed cell value
  logic        awHeld_q;
  logic        wHeld_q;
  prom_bit_pkg::wr_req_s wr_q;
  prom_bit_pkg::cell_pos_s pos;

  // Split a select value into row and column
  function automatic prom_bit_pkg::cell_pos_s decode_sel(input logic [7:0] sel);
    prom_bit_pkg::cell_pos_s p;
    p.row = sel[prom_bit_pkg::ROW_LSB +: prom_bit_pkg::IDX_W];
    p.col = sel[prom_bit_pkg::COL_LSB +: prom_bit_pkg::IDX_W];
    return p;
  endfunction : decode_sel

  //////////////////////////////////////////////////////////////////////////////
  // Array side

  // Plain binary increment of the select value walks rows then columns
  assign pos        = decode_sel(cellSel_q);
  assign cellSelect = {pos.col, pos.row};
  assign cellRow    = {3'h0, pos.row};
  // Enable depends only on the control bit, never on the sensed value
  assign programSupplyEnable = pgm_q;

  // Sense bit has no reset so reset leaves it as it was; erased cells sense low
  always_ff @(posedge mclk) begin
    senseMeta_q <= senseIn;
    sensed_q    <= senseMeta_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write channel

  logic wrFire;
  logic wrHit;
  logic [3:0]  wAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  // Address and data can arrive in either order; each is held once taken
  assign s_awready = !awHeld_q && !s_bvalid;
  assign s_wready  = !wHeld_q && !s_bvalid;
  assign wAddr  = awHeld_q ? wr_q.addr : s_awaddr;
  assign wData  = wHeld_q ? wr_q.data : s_wdata;
  assign wStrb  = wHeld_q ? wr_q.strb : s_wstrb;
  assign wrFire = (awHeld_q || (s_awvalid && s_awready)) &&
                  (wHeld_q || (s_wvalid && s_wready));
  assign wrHit  = (wAddr == prom_bit_pkg::CELL_SEL_ADDR) ||
                  (wAddr == prom_bit_pkg::STAT_CTRL_ADDR);

  // Capture of each half of a write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      wr_q     <= '0;
    end else if (wrFire) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        awHeld_q     <= 1'b1;
        wr_q.addr    <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        wHeld_q      <= 1'b1;
        wr_q.data    <= s_wdata;
        wr_q.strb    <= s_wstrb;
      end
    end
  end

  // Write response, unmapped address answers SLVERR
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= prom_bit_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wrHit ? prom_bit_pkg::RESP_OKAY : prom_bit_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  // Full byte stored, top two bits are spare storage only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cellSel_q <= prom_bit_pkg::CELL_SEL_RST;
    end else if (wrFire && wAddr == prom_bit_pkg::CELL_SEL_ADDR && wStrb[0]) begin
      cellSel_q <= wData[7:0];
    end
  end

  // Program control bit; cell goes to 1 while set, software times the pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pgm_q <= 1'b0;
    end else if (wrFire && wAddr == prom_bit_pkg::STAT_CTRL_ADDR && wStrb[0]) begin
      pgm_q <= wData[prom_bit_pkg::SC_PGM_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [7:0] statCtrl;

  // Row-zero flag decoded live from the select register
  always_comb begin
    statCtrl = 8'h00;
    statCtrl[prom_bit_pkg::SC_DATA_BIT] = sensed_q;
    statCtrl[prom_bit_pkg::SC_PGM_BIT]  = pgm_q;
    statCtrl[prom_bit_pkg::SC_ROWZ_BIT] = (pos.row == 3'h0);
  end

  assign s_arready = !s_rvalid;

  // One read at a time, data registered on acceptance
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= prom_bit_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= prom_bit_pkg::RESP_OKAY;
      if (s_araddr == prom_bit_pkg::CELL_SEL_ADDR) begin
        s_rdata <= {24'h000000, cellSel_q};
      end else if (s_araddr == prom_bit_pkg::STAT_CTRL_ADDR) begin
        s_rdata <= {24'h000000, statCtrl};
      end else begin
        s_rdata <= 32'h0000_0000;
        s_rresp <= prom_bit_pkg::RESP_SLVERR;
      end
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule : personality_prom_bit_access

//--- shared/prom_bit_pkg.sv
// Package: register map, field layout and bus types for the personality prom access block
package prom_bit_pkg;
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  CELL_SEL_ADDR   = 4'h0;   // Cell select register byte address
  localparam logic [3:0]  STAT_CTRL_ADDR  = 4'h4;   // Status and control register byte address
  localparam int          ROW_LSB         = 0;
  localparam int          COL_LSB         = 3;
  localparam int          IDX_W           = 3;
  localparam int          SEL_W           = 6;
  localparam logic [7:0]  CELL_SEL_RST    = 8'h00;
  localparam int          SC_PGM_BIT      = 1;      // Program supply enable position
  localparam int          SC_ROWZ_BIT     = 2;      // First row flag position
  localparam int          SC_DATA_BIT     = 7;      // Sensed cell value position
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Decoded cell position
  typedef struct packed {
    logic [IDX_W-1:0] col;
    logic [IDX_W-1:0] row;
  } cell_pos_s;

  // Write channel pair
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } wr_req_s;
endpackage : prom_bit_pkg

//--- tb/prom_bit_checker.sv
// Checker of bus handshakes and array select outputs
`timescale 1ns/1ps
module prom_bit_checker (
  input wire logic        mclk,                // Clock
  input wire logic        arst_n,              // Reset
  input wire logic        s_awready,           // Aw ready
  input wire logic        s_wready,            // W ready
  input wire logic        s_bvalid,            // B valid
  input wire logic        s_bready,            // B ready
  input wire logic        s_arready,           // Ar ready
  input wire logic        s_rvalid,            // R valid
  input wire logic        s_rready,            // R ready
  input wire logic [31:0] s_rdata,             // R data
  input wire logic [5:0]  cellRow,             // Row out
  input wire logic [5:0]  cellSelect,          // Cell out
  input wire logic        programSupplyEnable  // Supply enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  AST_ROW: assert property (cellRow == {3'h0, cellSelect[2:0]})
    else $error("row index wrong");
  // Outputs may only move on a completed write
  AST_SEL_WR: assert property ($changed(cellSelect) |-> $rose(s_bvalid))
    else $error("select moved without write");
  AST_PGM_WR: assert property ($changed(programSupplyEnable) |-> $rose(s_bvalid))
    else $error("enable moved without write");
  AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data not held");
  AST_B_REFUSE: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken during response");
  AST_R_REFUSE: assert property (s_rvalid |-> !s_arready)
    else $error("read taken during response");
  AST_R_UPPER: assert property (s_rvalid |-> s_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule : prom_bit_checker
bind personality_prom_bit_access prom_bit_checker i_chk (.mclk, .arst_n, .s_awready,
  .s_wready, .s_bvalid, .s_bready, .s_arready, .s_rvalid, .s_rready, .s_rdata, .cellRow,
  .cellSelect, .programSupplyEnable);

//--- tb/testbench.sv
// Self-checking bench for the prom access block
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] SEL = prom_bit_pkg::CELL_SEL_ADDR;
  localparam logic [3:0] STA = prom_bit_pkg::STAT_CTRL_ADDR;
  localparam logic [7:0] CORNER [4] = '{8'h07, 8'h08, 8'h3F, 8'hC0};
  logic        mclk = 1'b0, arst_n = 1'b0, senseIn = 1'b0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic [3:0]  s_awaddr = 4'h0, s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, got;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pgmEn;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [5:0]  cellSelect;
  logic [7:0]  seed = 8'h18;
  int          badCount = 0, comparisons = 0;
  personality_prom_bit_access i_dut (.mclk, .arst_n, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .cellRow(), .cellSelect, .senseIn, .programSupplyEnable(pgmEn));
  initial forever #2 mclk = ~mclk;
  ////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Status word: sensed bit 7, row-zero flag 2, program bit 1
  function automatic logic [31:0] stat(input logic [7:0] v, input logic p, input logic s);
    return {24'h0, s, 4'h0, v[2:0] == 3'h0, p, 1'b0};
  endfunction : stat
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Both halves offered together, each dropped once taken
  // Handshakes judged on settled values mid-cycle, released just after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic awTaken, wTaken, done;
    @(posedge mclk);
    s_awaddr <= a;
    s_wdata <= {24'h0, d};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge mclk);
      awTaken = s_awvalid && s_awready;
      wTaken = s_wvalid && s_wready;
      done = s_bvalid;
      resp = s_bresp;
      @(posedge mclk);
      if (awTaken) s_awvalid <= 1'b0;
      if (wTaken) s_wvalid <= 1'b0;
    end while (!done);
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic arTaken, done;
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge mclk);
      arTaken = s_arvalid && s_arready;
      done = s_rvalid;
      got = s_rdata;
      resp = s_rresp;
      @(posedge mclk);
      if (arTaken) s_arvalid <= 1'b0;
    end while (!done);
    s_rready <= 1'b0;
  endtask : rd
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : printVerdict
  ////////////////////////////////////////
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    rd(SEL);
    chk(got, 32'h0);
    rd(STA);
    chk(got, stat(8'h00, 1'b0, 1'b0));
    $display("test reset done");
    // Corners first: row wrap 07 to 08, last cell, spare bits only
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      v = (i < 4) ? CORNER[i] : seed;
      senseIn <= seed[3];
      wr(SEL, v);
      wr(STA, {6'h0, seed[0], 1'b0});
      chk({26'h0, cellSelect}, {26'h0, v[5:0]});
      chk({31'h0, pgmEn}, {31'h0, seed[0]});
      rd(SEL);
      chk(got, {24'h0, v});
      rd(STA);
      chk(got, stat(v, seed[0], seed[3]));
    end
    $display("test random done");
    wr(4'h8, 8'hFF);
    chk({30'h0, resp}, {30'h0, prom_bit_pkg::RESP_SLVERR});
    rd(SEL);
    chk(got, {24'h0, v});
    $display("test unmapped done");
    wr(STA, 8'h02);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    chk({31'h0, pgmEn}, 32'h0);
    rd(SEL);
    chk(got, 32'h0);
    $display("test midreset done");
    printVerdict();
  end
  // Watchdog well beyond the roughly five hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    printVerdict();
  end
endmodule : testbench
